// >>> common/dlcd_pkg.sv
`default_nettype none
package dlcd_pkg;
  localparam int CLK_NS       = 10;
  localparam int STBY_MAX_NS  = 5000;
  localparam int STBY_MAX_CYC = STBY_MAX_NS / CLK_NS;
  // register byte offsets
  localparam logic [3:0] OFS_CMD  = 4'h0;
  localparam logic [3:0] OFS_STAT = 4'h4;
  localparam logic [3:0] OFS_CLR  = 4'h8;
  // command word layout: command byte low, data byte next
  localparam int GC_LSB = 5;
  localparam int BT_LSB = 2;
  localparam int DB_LSB = 8;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  localparam logic       RETRY_RST = 1'b1;
  typedef enum logic [2:0] {
    GC_NONE = 3'h0, GC_STBY = 3'h1, GC_BREAK = 3'h2, GC_IFR_CRC = 3'h3,
    GC_TERM = 3'h4, GC_IFR_RAW = 3'h5, GC_RSV = 3'h6, GC_ABORT = 3'h7
  } dlcd_general_command_field_t;
  typedef enum logic [2:0] {
    BT_NONE = 3'h0, BT_DATA = 3'h1, BT_RSV = 3'h2, BT_LAST = 3'h3,
    BT_CFG = 3'h4, BT_FIRST = 3'h5, BT_CFG_NOW = 3'h6, BT_ONE = 3'h7
  } dlcd_btype_t;
  // transmit queue status field values
  typedef enum logic [1:0] {
    QS_EMPTY = 2'h0, QS_DATA = 2'h1, QS_FULL = 2'h3
  } dlcd_qstat_t;
  // tag carried with each byte pushed into the transmit queue
  typedef enum logic [1:0] {
    TG_MID = 2'h0, TG_FIRST = 2'h1, TG_LAST = 2'h2, TG_ONE = 2'h3
  } dlcd_tag_t;
  typedef struct packed {
    logic        valid;
    dlcd_tag_t   tag;
    logic [7:0]  data;
  } dlcd_push_t;
  typedef struct packed {
    logic bus_idle;   // no frame on the bus
    logic eod_seen;   // EOD passed, EOF not yet
    logic rx_error;   // receiver saw an error in the current frame
    logic tx_busy;    // own transmitter is sending
    logic tx_done;    // pulse: frame sent successfully
    logic arb_lost;   // pulse: attempt lost arbitration
    logic underrun;   // pulse: queue ran dry mid-frame
    logic q_full;     // transmit queue full
    logic block_mode; // transfer running in block mode
  } dlcd_link_t;
endpackage : dlcd_pkg
`default_nettype wire

// >>> logic/dlcd_cmd_decoder.sv
// Chosen here: the register offsets and the AXI4-Lite slave port.
`default_nettype none
module dlcd_cmd_decoder (
  input  wire logic                 CORE_CLK,    // 100 MHz core clock
  input  wire logic                 RESET_N,     // async reset, active low
  input  wire logic                 AWVALID,     // write address valid
  output logic                      AWREADY,     // write address ready
  input  wire logic [31:0]          AWADDR,      // write byte address
  input  wire logic [2:0]           AWPROT,      // unused protection
  input  wire logic                 WVALID,      // write data valid
  output logic                      WREADY,      // write data ready
  input  wire logic [31:0]          WDATA,       // write data
  input  wire logic [3:0]           WSTRB,       // byte lanes
  output logic                      BVALID,      // write response valid
  input  wire logic                 BREADY,      // write response ready
  output logic [1:0]                BRESP,       // write response code
  input  wire logic                 ARVALID,     // read address valid
  output logic                      ARREADY,     // read address ready
  input  wire logic [31:0]          ARADDR,      // read byte address
  input  wire logic [2:0]           ARPROT,      // unused protection
  output logic                      RVALID,      // read data valid
  input  wire logic                 RREADY,      // read data ready
  output logic [31:0]               RDATA,       // read data
  output logic [1:0]                RRESP,       // read response code
  input  wire logic                 CS_N,        // host chip select level
  input  wire dlcd_pkg::dlcd_link_t LINK,        // transmitter/receiver state
  output dlcd_pkg::dlcd_push_t      TXQ_OUT,     // byte into transmit queue
  output logic                      TXQ_FLUSH,   // pulse: empty transmit queue
  output logic                      TX_RESET,    // pulse: reset transmitter
  output logic                      BREAK_START, // pulse: drive break symbol
  output logic                      IFR_ARMED,   // IFR queued for next EOD
  output logic                      IFR_CRC,     // queued IFR carries CRC
  output logic                      CRC_COMPL,   // pulse: append inverted CRC
  output logic                      RETRY_EN,    // automatic retry allowed
  output logic                      STANDBY,     // low-power standby
  output logic [7:0]                CFG_DATA,    // configuration byte
  output logic                      CFG_LOAD     // pulse: apply CFG_DATA
);
  // ---------------- bus slave ----------------
  logic        aw_ff, w_ff, bv_ff, ar_ff, rv_ff;
  logic [3:0]  awa_ff, wst_ff;
  logic [31:0] wd_ff, rd_ff;
  logic [1:0]  br_ff, rr_ff;
  logic        wr_fire;

  assign AWREADY = !aw_ff && !bv_ff;
  assign WREADY  = !w_ff && !bv_ff;
  assign wr_fire = aw_ff && w_ff && !bv_ff;
  assign BVALID  = bv_ff;
  assign BRESP   = br_ff;
  assign ARREADY = !rv_ff;
  assign RVALID  = rv_ff;
  assign RDATA   = rd_ff;
  assign RRESP   = rr_ff;

  // hold address and data until both are in, in either order
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      aw_ff  <= 1'b0;
      w_ff   <= 1'b0;
      awa_ff <= 4'h0;
      wd_ff  <= 32'h0;
      wst_ff <= 4'h0;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_ff  <= 1'b1;
        awa_ff <= AWADDR[3:0];
      end else if (wr_fire) begin
        aw_ff <= 1'b0;
      end
      if (WVALID && WREADY) begin
        w_ff   <= 1'b1;
        wd_ff  <= WDATA;
        wst_ff <= WSTRB;
      end else if (wr_fire) begin
        w_ff <= 1'b0;
      end
    end
  end

  // write response; status is read only, holes answer with an error
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      bv_ff <= 1'b0;
      br_ff <= dlcd_pkg::RESP_OK;
    end else if (wr_fire) begin
      bv_ff <= 1'b1;
      br_ff <= (awa_ff == dlcd_pkg::OFS_CMD || awa_ff == dlcd_pkg::OFS_CLR)
               ? dlcd_pkg::RESP_OK : dlcd_pkg::RESP_ERR;
    end else if (BREADY) begin
      bv_ff <= 1'b0;
    end
  end

  // ---------------- command decode ----------------
  dlcd_pkg::dlcd_general_command_field_t  general_command_field;
  dlcd_pkg::dlcd_btype_t btype;
  logic [7:0] dbyte;
  logic lat, is_ifr, ifr_busy, ifr_drop, ifr_ok, abort, fresh;
  logic cmpl, empty, full_blk, push, term_now, term_done, ifr_fail;
  logic flush_now, cs_tog, clr_err;
  dlcd_pkg::dlcd_tag_t tag;
  logic stby_ff, pend_ff, cs_ff, retry_ff, tpend_ff, arm_ff, crc_ff;
  logic err_ff, cpl_ff, cfgp_ff;
  dlcd_pkg::dlcd_qstat_t qs_ff;

  // true for byte types that open a frame
  function automatic logic opens(input dlcd_pkg::dlcd_btype_t b);
    opens = (b == dlcd_pkg::BT_FIRST) || (b == dlcd_pkg::BT_ONE);
  endfunction : opens

  // nothing acts until the write that carries the command lane lands
  assign lat   = wr_fire && awa_ff == dlcd_pkg::OFS_CMD && wst_ff[0];
  assign general_command_field  = dlcd_pkg::dlcd_general_command_field_t'(wd_ff[dlcd_pkg::GC_LSB +: 3]);
  assign btype = dlcd_pkg::dlcd_btype_t'(wd_ff[dlcd_pkg::BT_LSB +: 3]);
  assign dbyte = wd_ff[dlcd_pkg::DB_LSB +: 8];
  assign clr_err = wr_fire && awa_ff == dlcd_pkg::OFS_CLR && wst_ff[0] && wd_ff[0];
  assign cs_tog  = CS_N != cs_ff;

  // IFR acceptance; a missing first byte also voids it
  assign is_ifr   = lat && (general_command_field == dlcd_pkg::GC_IFR_CRC || general_command_field == dlcd_pkg::GC_IFR_RAW);
  assign ifr_busy = is_ifr && LINK.tx_busy;
  assign ifr_drop = is_ifr && !LINK.tx_busy && (LINK.bus_idle || LINK.eod_seen
                    || LINK.rx_error || !opens(btype));
  assign ifr_ok   = is_ifr && !ifr_busy && !ifr_drop;
  assign abort    = lat && general_command_field == dlcd_pkg::GC_ABORT;
  assign ifr_fail = arm_ff && LINK.rx_error && !LINK.tx_busy;

  // after abort or an accepted IFR the queue counts as already empty
  assign fresh    = abort || ifr_ok;
  assign cmpl     = cpl_ff && !fresh;
  assign empty    = qs_ff == dlcd_pkg::QS_EMPTY || fresh;
  assign full_blk = LINK.q_full && LINK.block_mode && !fresh;

  // byte placement; a voided IFR loses its byte as well
  always_comb begin
    push = 1'b0;
    tag  = dlcd_pkg::TG_MID;
    if (lat && !(is_ifr && !ifr_ok)) begin
      case (btype)
        dlcd_pkg::BT_DATA: begin
          push = !full_blk && !cmpl && !empty;
        end
        dlcd_pkg::BT_LAST: begin
          push = !(cmpl && LINK.tx_busy) && !empty;
          tag  = dlcd_pkg::TG_LAST;
        end
        dlcd_pkg::BT_FIRST: begin
          push = !(cmpl && LINK.tx_busy) && !full_blk;
          tag  = dlcd_pkg::TG_FIRST;
        end
        dlcd_pkg::BT_ONE: begin
          push = !cmpl && !full_blk;
          tag  = dlcd_pkg::TG_ONE;
        end
        default: begin
          push = 1'b0;
        end
      endcase
    end
  end

  // terminate retry: wait for the attempt in flight or queued, else act now
  assign term_now  = lat && general_command_field == dlcd_pkg::GC_TERM && !LINK.tx_busy && !cpl_ff;
  assign term_done = tpend_ff && (LINK.tx_done || LINK.arb_lost);
  assign flush_now = fresh || ifr_busy || ifr_drop || ifr_fail || term_now || term_done;

  // queue strobes; a push in the flush cycle lands after the flush
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      TXQ_OUT     <= '0;
      TXQ_FLUSH   <= 1'b0;
      TX_RESET    <= 1'b0;
      BREAK_START <= 1'b0;
    end else begin
      TXQ_OUT.valid <= push;
      TXQ_OUT.tag   <= tag;
      TXQ_OUT.data  <= dbyte;
      TXQ_FLUSH     <= flush_now;
      TX_RESET      <= fresh || ifr_busy;
      BREAK_START   <= lat && general_command_field == dlcd_pkg::GC_BREAK;
    end
  end

  // queue status and complete-frame tracking
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      qs_ff  <= dlcd_pkg::QS_EMPTY;
      cpl_ff <= 1'b0;
    end else if (push) begin
      qs_ff  <= (tag == dlcd_pkg::TG_FIRST) ? dlcd_pkg::QS_DATA
              : (tag == dlcd_pkg::TG_MID) ? qs_ff : dlcd_pkg::QS_FULL;
      cpl_ff <= tag == dlcd_pkg::TG_LAST || tag == dlcd_pkg::TG_ONE;
    end else if (flush_now || (LINK.tx_done && cpl_ff)) begin
      qs_ff  <= dlcd_pkg::QS_EMPTY;
      cpl_ff <= 1'b0;
    end
  end

  // retry state; a new ordinary frame brings retry back
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      retry_ff <= dlcd_pkg::RETRY_RST;
      tpend_ff <= 1'b0;
    end else begin
      if (ifr_ok || term_now || term_done) begin
        retry_ff <= 1'b0;
      end else if (push && !is_ifr && (tag == dlcd_pkg::TG_FIRST || tag == dlcd_pkg::TG_ONE)) begin
        retry_ff <= 1'b1;
      end
      if (lat && general_command_field == dlcd_pkg::GC_TERM && !term_now) begin
        tpend_ff <= 1'b1;
      end else if (term_done || fresh) begin
        tpend_ff <= 1'b0;
      end
    end
  end
  // IFRs and block transfers never retry
  assign RETRY_EN = retry_ff && !arm_ff && !LINK.block_mode;

  // IFR arming lasts until the attempt ends or the frame turns bad
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      arm_ff <= 1'b0;
      crc_ff <= 1'b0;
    end else if (ifr_ok) begin
      arm_ff <= 1'b1;
      crc_ff <= general_command_field == dlcd_pkg::GC_IFR_CRC;
    end else if (abort || ifr_fail || LINK.tx_done || LINK.arb_lost) begin
      arm_ff <= 1'b0;
    end
  end
  assign IFR_ARMED = arm_ff;
  assign IFR_CRC   = crc_ff;

  // sticky error; setting beats a clear in the same cycle
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      err_ff    <= 1'b0;
      CRC_COMPL <= 1'b0;
    end else begin
      if (ifr_busy || (arm_ff && LINK.underrun)) begin
        err_ff <= 1'b1;
      end else if (clr_err) begin
        err_ff <= 1'b0;
      end
      CRC_COMPL <= arm_ff && crc_ff && LINK.underrun;
    end
  end

  // standby; any later write with a general command other than GC_NONE or GC_STBY wakes the block
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      stby_ff <= 1'b0;
      pend_ff <= 1'b0;
      cs_ff   <= 1'b1;
    end else begin
      cs_ff <= CS_N;
      if (lat && general_command_field == dlcd_pkg::GC_STBY) begin
        stby_ff <= LINK.bus_idle;
        pend_ff <= !LINK.bus_idle;
      end else if (pend_ff && cs_tog) begin
        pend_ff <= 1'b0;
      end else if (pend_ff && LINK.bus_idle) begin
        stby_ff <= 1'b1;
        pend_ff <= 1'b0;
      end else if (lat && general_command_field != dlcd_pkg::GC_NONE) begin
        stby_ff <= 1'b0;
      end
    end
  end
  assign STANDBY = stby_ff;

  // configuration: normal loads wait for an idle bus
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CFG_DATA <= 8'h00;
      CFG_LOAD <= 1'b0;
      cfgp_ff  <= 1'b0;
    end else begin
      CFG_LOAD <= 1'b0;
      if (lat && (btype == dlcd_pkg::BT_CFG || btype == dlcd_pkg::BT_CFG_NOW)) begin
        CFG_DATA <= dbyte;
        CFG_LOAD <= btype == dlcd_pkg::BT_CFG_NOW;
        cfgp_ff  <= btype == dlcd_pkg::BT_CFG;
      end else if (cfgp_ff && LINK.bus_idle) begin
        CFG_LOAD <= 1'b1;
        cfgp_ff  <= 1'b0;
      end
    end
  end

  // read side: one beat, answered the cycle after acceptance
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rv_ff <= 1'b0;
      rd_ff <= 32'h0;
      rr_ff <= dlcd_pkg::RESP_OK;
    end else if (ARVALID && ARREADY) begin
      rv_ff <= 1'b1;
      rd_ff <= 32'h0;
      rr_ff <= dlcd_pkg::RESP_OK;
      case (ARADDR[3:0])
        dlcd_pkg::OFS_CMD, dlcd_pkg::OFS_CLR: rd_ff <= 32'h0;
        dlcd_pkg::OFS_STAT: begin
          rd_ff <= {22'h0, cpl_ff, tpend_ff, err_ff, crc_ff, arm_ff,
                    pend_ff, stby_ff, retry_ff, qs_ff};
        end
        default: rr_ff <= dlcd_pkg::RESP_ERR;
      endcase
    end else if (RREADY) begin
      rv_ff <= 1'b0;
    end
  end

  // ---------------- checks ----------------
  localparam int StbyMax = dlcd_pkg::STBY_MAX_CYC;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_stby_wait;
    pend_ff && !cs_tog ##1 LINK.bus_idle && !cs_tog && !lat;
  endsequence
  property p_stby_late;
    s_stby_wait |-> ##[1:StbyMax] STANDBY;
  endproperty
  a_stby_late: assert property (p_stby_late) else $error("standby late");
  property p_stby_now;
    lat && general_command_field == dlcd_pkg::GC_STBY && LINK.bus_idle |=> STANDBY && !pend_ff;
  endproperty
  a_stby_now: assert property (p_stby_now) else $error("standby not immediate");
  property p_cs_cancel;
    pend_ff && cs_tog && !lat |=> !pend_ff ##1 !STANDBY || lat;
  endproperty
  a_cs_cancel: assert property (p_cs_cancel) else $error("standby not cancelled");
  property p_break;
    lat && general_command_field == dlcd_pkg::GC_BREAK |=> BREAK_START ##1 !BREAK_START || lat;
  endproperty
  a_break: assert property (p_break) else $error("break not started");
  property p_nolatch;
    !lat |=> !BREAK_START && !TX_RESET;
  endproperty
  a_nolatch: assert property (p_nolatch) else $error("action without latch");
  property p_ifr_ok;
    ifr_ok |=> TX_RESET && TXQ_FLUSH && !RETRY_EN && IFR_ARMED && TXQ_OUT.valid;
  endproperty
  a_ifr_ok: assert property (p_ifr_ok) else $error("ifr not queued");
  property p_ifr_drop;
    ifr_drop && !tpend_ff |=> TXQ_FLUSH && !TX_RESET && retry_ff == $past(retry_ff)
      && qs_ff == dlcd_pkg::QS_EMPTY && !TXQ_OUT.valid;
  endproperty
  a_ifr_drop: assert property (p_ifr_drop) else $error("ifr drop wrong");
  property p_ifr_busy;
    ifr_busy |=> err_ff && TXQ_FLUSH && !TXQ_OUT.valid;
  endproperty
  a_ifr_busy: assert property (p_ifr_busy) else $error("ifr busy not flagged");
  property p_underrun;
    arm_ff && crc_ff && LINK.underrun |=> CRC_COMPL && err_ff;
  endproperty
  a_underrun: assert property (p_underrun) else $error("underrun unflagged");
  property p_term;
    term_done && !lat |=> TXQ_FLUSH && !retry_ff && !tpend_ff;
  endproperty
  a_term: assert property (p_term) else $error("retry not ended");
  property p_abort;
    abort && opens(btype) |=> TX_RESET && TXQ_FLUSH && TXQ_OUT.valid;
  endproperty
  a_abort: assert property (p_abort) else $error("abort wrong");
  property p_first;
    push && tag == dlcd_pkg::TG_FIRST |=> qs_ff == dlcd_pkg::QS_DATA;
  endproperty
  a_first: assert property (p_first) else $error("status not data");
  property p_last;
    push && tag == dlcd_pkg::TG_LAST |=> qs_ff == dlcd_pkg::QS_FULL ##1 qs_ff != dlcd_pkg::QS_DATA;
  endproperty
  a_last: assert property (p_last) else $error("status not full");
  property p_rsv;
    lat && general_command_field == dlcd_pkg::GC_RSV && btype == dlcd_pkg::BT_RSV && !tpend_ff && !arm_ff
      |=> !TXQ_FLUSH && !TX_RESET && !TXQ_OUT.valid;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved code acted");
  property p_data_empty;
    lat && !is_ifr && !abort && btype == dlcd_pkg::BT_DATA && qs_ff == dlcd_pkg::QS_EMPTY
      |=> !TXQ_OUT.valid;
  endproperty
  a_data_empty: assert property (p_data_empty) else $error("byte into empty queue");
endmodule : dlcd_cmd_decoder
`default_nettype wire

// >>> tb/dlcd_link_model.sv
`default_nettype none
module dlcd_link_model (
  input  wire logic                 clk,  // core clock
  output var dlcd_pkg::dlcd_link_t  link  // line state seen by decoder
);
  timeunit 1ns;
  timeprecision 100ps;
  // quiet idle bus until told otherwise
  initial begin
    link          = '0;
    link.bus_idle = 1'b1;
  end
  // levels move just after an edge so they stand whole cycles
  task automatic lvl(input logic idle, eod, rxe, txb, blk);
    @(posedge clk);
    link.bus_idle   <= idle;
    link.eod_seen   <= eod;
    link.rx_error   <= rxe;
    link.tx_busy    <= txb;
    link.block_mode <= blk;
  endtask : lvl
  // one-cycle events: {done, lost, underrun}
  task automatic pulse(input logic [2:0] p);
    @(posedge clk);
    {link.tx_done, link.arb_lost, link.underrun} <= p;
    @(posedge clk);
    {link.tx_done, link.arb_lost, link.underrun} <= 3'h0;
  endtask : pulse
  // queue-full level, kept apart so the level task stays short
  task automatic qfull(input logic full);
    @(posedge clk);
    link.q_full <= full;
  endtask : qfull
endmodule : dlcd_link_model
`default_nettype wire

// >>> tb/dlc_host_command_decoder_tb.sv
`default_nettype none
module dlc_host_command_decoder_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst_n = 1'b0, cs_n = 1'b1, awvalid = 1'b0, wvalid = 1'b0;
  logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, flush, txrst, brk, armed;
  logic ifr_crc, compl, retry, stby, cfg_load;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, st;
  logic [3:0]  wstrb = '0;
  logic [1:0]  bresp, rresp, resp;
  logic [7:0]  cfg_data;
  logic [8:0]  tbl [6];
  int          mismatches, n_tests, cyc, n_push, n_flush, n_rst, n_brk, n_compl, n_cfg, f;
  dlcd_pkg::dlcd_link_t link;
  dlcd_pkg::dlcd_push_t txq, last_push;
  dlcd_cmd_decoder i_dlcd_cmd_decoder (
    .CORE_CLK(clk), .RESET_N(rst_n), .AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr),
    .AWPROT(3'h0), .WVALID(wvalid), .WREADY(wready), .WDATA(wdata), .WSTRB(wstrb),
    .BVALID(bvalid), .BREADY(bready), .BRESP(bresp), .ARVALID(arvalid), .ARREADY(arready),
    .ARADDR(araddr), .ARPROT(3'h0), .RVALID(rvalid), .RREADY(rready), .RDATA(rdata),
    .RRESP(rresp), .CS_N(cs_n), .LINK(link), .TXQ_OUT(txq), .TXQ_FLUSH(flush),
    .TX_RESET(txrst), .BREAK_START(brk), .IFR_ARMED(armed), .IFR_CRC(ifr_crc),
    .CRC_COMPL(compl), .RETRY_EN(retry), .STANDBY(stby), .CFG_DATA(cfg_data),
    .CFG_LOAD(cfg_load));
  dlcd_link_model i_dlcd_link_model (.clk(clk), .link(link));
  always #5 clk = ~clk;
  // tally the one-cycle outputs so checks need not hit the exact edge
  always @(posedge clk) begin
    if (txq.valid === 1'b1) begin
      n_push    <= n_push + 1;
      last_push <= txq;
    end
    n_flush <= n_flush + int'(flush === 1'b1);
    n_rst   <= n_rst + int'(txrst === 1'b1);
    n_brk   <= n_brk + int'(brk === 1'b1);
    n_compl <= n_compl + int'(compl === 1'b1);
    n_cfg   <= n_cfg + int'(cfg_load === 1'b1);
    cyc     <= cyc + 1;
    if (cyc == 20000)
      hang();
  end
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task automatic hang;
    mismatches++;
    conclude();
  endtask : hang
  task automatic chk(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic chb(input logic got, exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chb
  // handshakes are judged mid-cycle, released by the following edge
  task automatic wr(input logic [31:0] a, d, input logic [3:0] s);
    logic aw, w, b;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    b = 1'b0;
    // no cycle count assumed here: only the bench ceiling ends a stuck wait
    while (!b) begin
      @(negedge clk);
      aw   = awvalid && awready;
      w    = wvalid && wready;
      b    = bvalid;
      resp = bresp;
      @(posedge clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
    end
  endtask : wr
  task automatic rd(input logic [31:0] a);
    logic ar, rv;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    rv = 1'b0;
    while (!rv) begin
      @(negedge clk);
      ar   = arvalid && arready;
      rv   = rvalid;
      st   = rdata;
      resp = rresp;
      @(posedge clk);
      if (ar) arvalid <= 1'b0;
      if (rv) rready <= 1'b0;
    end
  endtask : rd
  // command effects land two edges after the write answer
  task automatic cmd(input logic [2:0] gc, bt, input logic [7:0] db);
    wr(32'h0, {16'h0, db, gc, bt, 2'h0}, 4'h1);
    repeat (2) @(posedge clk);
  endtask : cmd
  initial begin
    tbl = '{9'h160, 9'h0d0, 9'h150, 9'h0c8, 9'h0c5, 9'h0c2};
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(32'h4);
    chk(st, 32'h4);
    rd(32'hc);
    chk(32'(resp), 32'(dlcd_pkg::RESP_ERR));
    wr(32'h4, 32'h0, 4'hf);
    chk(32'(resp), 32'(dlcd_pkg::RESP_ERR));
    wr(32'h0, 32'h40, 4'h0);
    repeat (2) @(posedge clk);
    chk(n_brk, 0);
    cmd(3'h2, 3'h0, 8'h0);
    chk(n_brk, 1);
    cmd(3'h6, 3'h2, 8'h99);
    chk(n_push + n_flush + n_rst, 0);
    $display("test bus done");
    cmd(3'h0, 3'h5, 8'h5a);
    rd(32'h4);
    chk(32'(st[1:0]), 32'h1);
    chk(32'(last_push), 32'({1'b1, dlcd_pkg::TG_FIRST, 8'h5a}));
    cmd(3'h0, 3'h1, 8'h33);
    chk(32'(last_push), 32'({1'b1, dlcd_pkg::TG_MID, 8'h33}));
    cmd(3'h0, 3'h3, 8'hc7);
    rd(32'h4);
    chk(32'(st[1:0]), 32'h3);
    cmd(3'h0, 3'h1, 8'h44);
    chk(n_push, 3);
    cmd(3'h7, 3'h5, 8'h11);
    chk(n_rst + n_flush, 2);
    chk(32'(last_push), 32'({1'b1, dlcd_pkg::TG_FIRST, 8'h11}));
    cmd(3'h7, 3'h0, 8'h0);
    cmd(3'h0, 3'h1, 8'h22);
    chk(n_push, 4);
    cmd(3'h0, 3'h6, 8'hc3);
    chk({n_cfg[23:0], cfg_data}, 32'h1c3);
    // normal config byte waits for the bus to go quiet
    i_dlcd_link_model.lvl(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    cmd(3'h0, 3'h4, 8'h5c);
    chk({n_cfg[23:0], cfg_data}, 32'h15c);
    i_dlcd_link_model.lvl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    repeat (3) @(posedge clk);
    chk({n_cfg[23:0], cfg_data}, 32'h25c);
    cmd(3'h4, 3'h0, 8'h0);
    chb(retry, 1'b0);
    $display("test load done");
    // terminate with a frame waiting, then with one on the wire
    for (int k = 0; k < 2; k++) begin
      i_dlcd_link_model.lvl(1'b0, 1'b0, 1'b0, k[0], 1'b0);
      cmd(3'h0, 3'h7, 8'h60);
      cmd(3'h4, 3'h0, 8'h0);
      chb(retry, 1'b1);
      f = n_flush;
      i_dlcd_link_model.pulse(k[0] ? 3'h2 : 3'h4);
      repeat (3) @(posedge clk);
      chb(retry, 1'b0);
      chk(n_flush, f + 1);
    end
    i_dlcd_link_model.lvl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    cmd(3'h0, 3'h5, 8'h01);
    // table: command, idle, eod, rx error, tx busy, armed, error
    foreach (tbl[i]) begin
      i_dlcd_link_model.lvl(tbl[i][5], tbl[i][4], tbl[i][3], tbl[i][2], 1'b0);
      cmd(tbl[i][8:6], 3'h5, 8'h80);
      rd(32'h4);
      chk(st & 32'ha7, {24'h0, tbl[i][0], 1'b0, tbl[i][1], 2'h0, ~tbl[i][1], 1'b0, tbl[i][1]});
      chb(armed, tbl[i][1]);
      wr(32'h8, 32'h1, 4'hf);
    end
    chb(ifr_crc, 1'b1);
    // second response byte goes in at once, without the response command
    cmd(3'h0, 3'h1, 8'h81);
    chk(32'(last_push), 32'({1'b1, dlcd_pkg::TG_MID, 8'h81}));
    i_dlcd_link_model.pulse(3'h1);
    repeat (3) @(posedge clk);
    rd(32'h4);
    chk({n_compl[30:0], st[7]}, 32'h3);
    i_dlcd_link_model.pulse(3'h4);
    cmd(3'h0, 3'h5, 8'h02);
    chb(retry, 1'b1);
    i_dlcd_link_model.lvl(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    repeat (2) @(posedge clk);
    chb(retry, 1'b0);
    // a full queue in block mode refuses data bytes
    f = n_push;
    i_dlcd_link_model.qfull(1'b1);
    cmd(3'h0, 3'h1, 8'h03);
    chk(n_push, f);
    i_dlcd_link_model.qfull(1'b0);
    cmd(3'h0, 3'h1, 8'h04);
    chk(n_push, f + 1);
    $display("test ifr done");
    i_dlcd_link_model.lvl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    cmd(3'h1, 3'h0, 8'h0);
    chb(stby, 1'b1);
    cmd(3'h2, 3'h0, 8'h0);
    i_dlcd_link_model.lvl(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    cmd(3'h1, 3'h0, 8'h0);
    chb(stby, 1'b0);
    i_dlcd_link_model.lvl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    f = 0;
    while (stby !== 1'b1 && f < 500) begin
      @(posedge clk);
      f++;
    end
    chb(stby, 1'b1);
    cmd(3'h2, 3'h0, 8'h0);
    i_dlcd_link_model.lvl(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    cmd(3'h1, 3'h0, 8'h0);
    @(posedge clk) cs_n <= 1'b0;
    i_dlcd_link_model.lvl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    repeat (10) @(posedge clk);
    chb(stby, 1'b0);
    $display("test standby done");
    conclude();
  end
endmodule : dlc_host_command_decoder_tb
`default_nettype wire
